// >>> verilog/usart_status_consts.vh
`ifndef USART_STATUS_CONSTS_VH
`define USART_STATUS_CONSTS_VH
// register byte offsets
`define OFS_IRQ_SET       4'h0
`define OFS_IRQ_CLR       4'h4
`define OFS_IRQ_MASK      4'h8
`define OFS_CHAN_STATUS   4'hc
`define OFS_MODE          4'h0
// mode register offset and those after it are five-bit byte offsets
`define OFS_MODE_REG      5'h10
`define OFS_CMD_REG       5'h14
`define OFS_RX_DATA       5'h18
// status bit positions
`define B_RECEIVE_READY   0
`define B_TRANSMIT_READY   1
`define B_BRK     2
`define B_RECEIVE_DMA_END   3
`define B_TRANSMIT_DMA_END   4
`define B_OVR     5
`define B_FRAME   6
`define B_PARITY_ERROR    7
`define B_TMO     8
`define B_TRANSMITTER_EMPTY 9
`define B_ITERATION_FLAG    10
`define B_TRANSMIT_BUFFER_EMPTY  11
`define B_RECEIVE_BUFFER_FULL  12
`define B_NACK    13
`define B_RING_CHANGE_FLAG    16
`define B_CLEAR_SEND_CHANGE_FLAG   19
// valid mask of event bits
`define EVENT_MASK 32'h000f3fff
// mode register fields
`define M_OVER    19
`define M_INHIBIT_NONACK   20
`define M_SUCCESSIVE_NONACK_LIMIT  21
`define M_ITERATION_FLAG_LO 24
`define M_ITERATION_FLAG_HI 26
`define M_FILTER  28
`define MODE_RESET 32'h00000000
// command register bits
`define C_RXEN    4
`define C_RXDIS   5
`define C_TXEN    6
`define C_TXDIS   7
`define C_RESET_STATUS_COMMAND  8
`define C_START_BREAK_COMMAND  9
`define C_START_TIMEOUT_COMMAND   11
`define C_RSTIT   13
`define C_RSTNACK 14
`endif

// >>> verilog/usart_status.v
// Operation
// - inhibit option set means no non-acknowledge is sent after parity error.
// - limit option clear: non-acknowledge sent on every parity error.
// - limit option set: count errors, nack until limit, then stop and flag iteration.
// - retry-limit field sets the maximum repetitions in T=0 operation.
// - filter option set: receive line is two-of-three majority of three samples.
// - write-only enable register, events at bits 0-13 and 16-19.
// - write-only disable register with same positions removes event sources.
// - read-only mask register shows which events are enabled.
// - receive ready set on complete character, cleared on data read or disable.
// - receive ready reasserts on re-enable if characters arrived meanwhile.
// - transmit ready low while holding busy, break pending or transmitter disabled.
// - transmit ready rises as soon as transmitter enabled with no character waiting.
// - break flag sticky on break or end of break until reset-status.
// - receive dma end bit follows the receive channel signal unlatched.
// - transmit dma end bit follows the transmit channel signal unlatched.
// - overrun flag sticky until reset-status.
// - modem change flags set on any line change, cleared by status read.
// - transmitter empty only when holding and shift registers are both empty.
// - framing and parity flags sticky until reset-status.
// - time-out flag set on time-out, kept until next start-time-out command.
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`include "usart_status_consts.vh"
module usart_status (
   input  wire        core_clk,
   input  wire        rst_b,
   input  wire [4:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output wire        waitrequest,
   input  wire        rx_char_done,
   input  wire        rx_parity_err,
   input  wire        rx_frame_err,
   input  wire        rx_overrun,
   input  wire        rx_break_event,
   input  wire        rx_timeout_event,
   input  wire        rx_nack_seen,
   input  wire [8:0]  rx_char,
   input  wire        tx_holding_full,
   input  wire        tx_shift_busy,
   input  wire        tx_break_pending,
   input  wire        receive_dma_end,
   input  wire        transmit_dma_end,
   input  wire        transmit_buffer_empty,
   input  wire        receive_buffer_full,
   input  wire [3:0]  modem_lines,
   input  wire        rx_line,
   input  wire        sample_tick,
   output wire        rx_line_filtered,
   output reg         nack_send,
   output wire        oversample_8,
   output wire [2:0]  bit_samples_m1,
   output wire        rx_enabled,
   output wire        tx_enabled,
   output wire        irq
);

// ----------------------------------------------------------------
// bus slave
// ----------------------------------------------------------------
reg         ack_reg;
wire        req = (read | write) & ~ack_reg;
wire        wr_go = write & ack_reg;
wire        rd_go = read & ack_reg;
assign waitrequest = ~ack_reg;

reg  [31:0] mode_reg;
reg  [31:0] mask_reg;
reg  [31:0] stat_reg;
reg         rx_en_reg;
reg         tx_en_reg;
reg         rx_pend_reg;
reg  [2:0]  iteration_flag_cnt_reg;
reg  [3:0]  modem_prev_reg;
reg  [8:0]  rx_data_reg;
reg  [2:0]  filt_reg;
reg  [31:0] stat_view;

wire [31:0] cmd = (wr_go && address == `OFS_CMD_REG) ? writedata : 32'h0;
// read-side effects fire on the capture edge so nothing set after the capture is lost
wire        csr_rd = req && read && address == {1'b0, `OFS_CHAN_STATUS};
wire        rhr_rd = req && read && address == `OFS_RX_DATA;
wire [2:0]  max_iteration_flag = mode_reg[`M_ITERATION_FLAG_HI:`M_ITERATION_FLAG_LO];
wire        iteration_flag_hit = mode_reg[`M_SUCCESSIVE_NONACK_LIMIT] && (iteration_flag_cnt_reg >= max_iteration_flag);

always @(posedge core_clk or negedge rst_b) begin
   if (!rst_b)
      ack_reg <= 1'b0;
   else
      ack_reg <= req;
end

// ----------------------------------------------------------------
// mode, mask and enables
// ----------------------------------------------------------------
assign oversample_8   = mode_reg[`M_OVER];
assign bit_samples_m1 = 3'h7;  // low bits only, same in both modes
assign rx_enabled     = rx_en_reg;
assign tx_enabled     = tx_en_reg;
// 16 or 8 samples per bit handed to the baud divider

always @(posedge core_clk or negedge rst_b) begin
   if (!rst_b) begin
      mode_reg  <= `MODE_RESET;
      mask_reg  <= 32'h0;
      rx_en_reg <= 1'b0;
      tx_en_reg <= 1'b0;
   end else begin
      if (wr_go && address == `OFS_MODE_REG)
         mode_reg <= writedata;
      if (wr_go && address == {1'b0, `OFS_IRQ_SET})
         mask_reg <= mask_reg | (writedata & `EVENT_MASK);
      else if (wr_go && address == {1'b0, `OFS_IRQ_CLR})
         mask_reg <= mask_reg & ~(writedata & `EVENT_MASK);
      if (cmd[`C_RXDIS])
         rx_en_reg <= 1'b0;
      else if (cmd[`C_RXEN])
         rx_en_reg <= 1'b1;
      if (cmd[`C_TXDIS])
         tx_en_reg <= 1'b0;
      else if (cmd[`C_TXEN])
         tx_en_reg <= 1'b1;
   end
end

// ----------------------------------------------------------------
// receive line filter
// ----------------------------------------------------------------
always @(posedge core_clk or negedge rst_b) begin
   if (!rst_b)
      filt_reg <= 3'h7;
   else if (sample_tick)
      filt_reg <= {filt_reg[1:0], rx_line};
end

wire vote = (filt_reg[0] & filt_reg[1]) | (filt_reg[1] & filt_reg[2]) | (filt_reg[0] & filt_reg[2]);
assign rx_line_filtered = mode_reg[`M_FILTER] ? vote : rx_line;

// ----------------------------------------------------------------
// smart-card non-acknowledge
// ----------------------------------------------------------------
always @(posedge core_clk or negedge rst_b) begin
   if (!rst_b) begin
      nack_send    <= 1'b0;
      iteration_flag_cnt_reg <= 3'h0;
   end else begin
      nack_send <= 1'b0;
      if (rx_char_done && rx_parity_err) begin
         if (!mode_reg[`M_INHIBIT_NONACK] && !iteration_flag_hit)
            nack_send <= 1'b1;
         if (mode_reg[`M_SUCCESSIVE_NONACK_LIMIT] && !iteration_flag_hit)
            iteration_flag_cnt_reg <= iteration_flag_cnt_reg + 3'h1;
      end else if (rx_char_done || cmd[`C_RSTIT]) begin
         iteration_flag_cnt_reg <= 3'h0;
      end
   end
end

// ----------------------------------------------------------------
// status flags
// ----------------------------------------------------------------
wire [3:0] modem_chg = modem_lines ^ modem_prev_reg;
wire       sta_clr   = cmd[`C_RESET_STATUS_COMMAND];

always @(posedge core_clk or negedge rst_b) begin
   if (!rst_b) begin
      stat_reg       <= 32'h0;
      rx_pend_reg    <= 1'b0;
      modem_prev_reg <= 4'h0;
      rx_data_reg    <= 9'h0;
   end else begin
      modem_prev_reg <= modem_lines;
      if (rx_char_done)
         rx_data_reg <= rx_char;
      // receive ready: set wins over read clear
      if (!rx_en_reg) begin
         stat_reg[`B_RECEIVE_READY] <= 1'b0;
         if (rx_char_done)
            rx_pend_reg <= 1'b1;
         if (cmd[`C_RXEN] && !cmd[`C_RXDIS] && (rx_pend_reg || rx_char_done))
            stat_reg[`B_RECEIVE_READY] <= 1'b1;
      end else if (rx_char_done)
         stat_reg[`B_RECEIVE_READY] <= 1'b1;
      else if (rhr_rd)
         stat_reg[`B_RECEIVE_READY] <= 1'b0;
      if (rx_en_reg)
         rx_pend_reg <= 1'b0;
      if (rx_break_event)
         stat_reg[`B_BRK] <= 1'b1;
      else if (sta_clr)
         stat_reg[`B_BRK] <= 1'b0;
      if (rx_overrun)
         stat_reg[`B_OVR] <= 1'b1;
      else if (sta_clr)
         stat_reg[`B_OVR] <= 1'b0;
      if (rx_char_done && rx_frame_err)
         stat_reg[`B_FRAME] <= 1'b1;
      else if (sta_clr)
         stat_reg[`B_FRAME] <= 1'b0;
      if (rx_char_done && rx_parity_err)
         stat_reg[`B_PARITY_ERROR] <= 1'b1;
      else if (sta_clr)
         stat_reg[`B_PARITY_ERROR] <= 1'b0;
      if (rx_timeout_event)
         stat_reg[`B_TMO] <= 1'b1;
      else if (cmd[`C_START_TIMEOUT_COMMAND])
         stat_reg[`B_TMO] <= 1'b0;
      if (rx_char_done && rx_parity_err && iteration_flag_hit)
         stat_reg[`B_ITERATION_FLAG] <= 1'b1;
      else if (sta_clr || cmd[`C_RSTIT])
         stat_reg[`B_ITERATION_FLAG] <= 1'b0;
      if (rx_nack_seen)
         stat_reg[`B_NACK] <= 1'b1;
      else if (cmd[`C_RSTNACK])
         stat_reg[`B_NACK] <= 1'b0;
      // change flags cleared by status read, new change wins
      stat_reg[`B_CLEAR_SEND_CHANGE_FLAG:`B_RING_CHANGE_FLAG] <= modem_chg | (csr_rd ? 4'h0 : stat_reg[`B_CLEAR_SEND_CHANGE_FLAG:`B_RING_CHANGE_FLAG]);
   end
end

// ----------------------------------------------------------------
// status view and interrupt
// ----------------------------------------------------------------
always @* begin
   stat_view = stat_reg & `EVENT_MASK;
   stat_view[`B_TRANSMIT_READY]   = tx_en_reg & ~tx_holding_full & ~tx_break_pending;
   stat_view[`B_RECEIVE_DMA_END]   = receive_dma_end;
   stat_view[`B_TRANSMIT_DMA_END]   = transmit_dma_end;
   stat_view[`B_TRANSMITTER_EMPTY] = tx_en_reg & ~tx_holding_full & ~tx_shift_busy;
   stat_view[`B_TRANSMIT_BUFFER_EMPTY]  = transmit_buffer_empty;
   stat_view[`B_RECEIVE_BUFFER_FULL]  = receive_buffer_full;
   stat_view[23:20]      = modem_lines;
end

assign irq = |(stat_view & mask_reg & `EVENT_MASK);

always @(posedge core_clk or negedge rst_b) begin
   if (!rst_b)
      readdata <= 32'h0;
   else if (req && read) begin
      case (address)
         {1'b0, `OFS_IRQ_MASK}:    readdata <= mask_reg;
         {1'b0, `OFS_CHAN_STATUS}: readdata <= stat_view;
         `OFS_MODE_REG:            readdata <= mode_reg;
         `OFS_RX_DATA:             readdata <= {23'h0, rx_data_reg};
         default:                  readdata <= 32'h0;
      endcase
   end
end

endmodule

// >>> testbench/usart_status_monitor.sv
`timescale 1ns/10ps
`include "usart_status_consts.vh"
module usart_status_monitor (
   input wire        core_clk, rst_b, read, write, waitrequest, rx_char_done, rx_parity_err,
   input wire        receive_dma_end, transmit_dma_end, nack_send, oversample_8, irq,
   input wire [4:0]  address,
   input wire [31:0] writedata, readdata
);
   logic [31:0] msk_reg;
   wire         done_wr = write && !waitrequest;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // ----
   // shadow of the enabled event set
   // ----
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         msk_reg <= 32'h0;
      else if (done_wr && address == 5'h00)
         msk_reg <= msk_reg | (writedata & `EVENT_MASK);
      else if (done_wr && address == 5'h04)
         msk_reg <= msk_reg & ~writedata;
   end
   wait_once_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("access left waiting");
   idle_wait_a: assert property (!read && !write |-> waitrequest)
      else $error("answer without request");
   read_stand_a: assert property (!read |=> $stable(readdata))
      else $error("read data moved");
   mask_view_a: assert property (read && !waitrequest && address == 5'h08 |-> readdata == msk_reg)
      else $error("mask view wrong");
   rx_dma_a: assert property (receive_dma_end && msk_reg[3] |-> irq)
      else $error("rx dma end gives no irq");
   tx_dma_a: assert property (transmit_dma_end && msk_reg[4] |-> irq)
      else $error("tx dma end gives no irq");
   quiet_irq_a: assert property (msk_reg == 32'h0 |-> !irq)
      else $error("irq while all masked");
   nack_cause_a: assert property (nack_send |-> $past(rx_char_done && rx_parity_err))
      else $error("nack without parity error");
   over_mode_a: assert property ($changed(oversample_8) |-> $past(done_wr && address == 5'h10))
      else $error("oversampling moved without mode write");
endmodule
bind usart_status usart_status_monitor i_mon (.core_clk(core_clk), .rst_b(rst_b), .read(read), .write(write),
   .waitrequest(waitrequest), .rx_char_done(rx_char_done), .rx_parity_err(rx_parity_err), .irq(irq),
   .receive_dma_end(receive_dma_end), .transmit_dma_end(transmit_dma_end), .nack_send(nack_send),
   .oversample_8(oversample_8), .address(address), .writedata(writedata), .readdata(readdata));

// >>> testbench/serial_line_peer.sv
`timescale 1ns/10ps
module serial_line_peer (
   input  wire        core_clk,
   input  wire [3:0]  modem_set,
   output logic       rx_line,
   output logic       sample_tick,
   output logic [3:0] modem_lines
);
   logic [1:0] div_reg = 2'h0;
   initial begin
      rx_line = 1'b1;
      sample_tick = 1'b0;
      modem_lines = 4'h0;
   end
   // ----
   // noisy line sampled every fourth cycle, modem levels follow the bench
   // ----
   always @(posedge core_clk) begin
      div_reg <= div_reg + 2'h1;
      sample_tick <= div_reg == 2'h3;
      modem_lines <= modem_set;
      if (div_reg == 2'h3)
         rx_line <= 1'($urandom_range(1, 0));
   end
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
`include "usart_status_consts.vh"
module tb_top;
   logic        core_clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0;
   logic [4:0]  address = 5'h0;
   logic [31:0] writedata = 32'h0, rd, w, exp_m = 32'h0;
   logic        rx_char_done = 1'b0, rx_parity_err = 1'b0, rx_frame_err = 1'b0, rx_overrun = 1'b0;
   logic        rx_break_event = 1'b0, tx_holding_full = 1'b0, tx_shift_busy = 1'b0, tx_break_pending = 1'b0;
   logic        receive_dma_end = 1'b0, transmit_dma_end = 1'b0;
   logic [8:0]  rx_char = 9'h0;
   logic [3:0]  modem_set = 4'h0;
   wire  [31:0] readdata;
   wire  [3:0]  modem_lines;
   wire         waitrequest, rx_line, sample_tick, rx_line_filtered, nack_send, oversample_8, irq;
   int          fail_count = 0, n_checks = 0, cycles = 0;
   logic [2:0]  hist = 3'h7;
   usart_status i_dut (.core_clk, .rst_b, .address, .read, .write, .writedata, .readdata, .waitrequest,
      .rx_char_done, .rx_parity_err, .rx_frame_err, .rx_overrun, .rx_break_event, .rx_timeout_event(1'b0),
      .rx_nack_seen(1'b0), .rx_char, .tx_holding_full, .tx_shift_busy, .tx_break_pending, .receive_dma_end,
      .transmit_dma_end, .transmit_buffer_empty(1'b0), .receive_buffer_full(1'b0), .modem_lines, .rx_line,
      .sample_tick, .rx_line_filtered, .nack_send, .oversample_8, .bit_samples_m1(), .rx_enabled(),
      .tx_enabled(), .irq);
   serial_line_peer i_peer (.core_clk, .modem_set, .rx_line, .sample_tick, .modem_lines);
   // ----
   // helpers
   // ----
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (sample_tick)
         hist <= {hist[1:0], rx_line};
   end
   function automatic logic maj(input logic [2:0] h);
      return (h[0] & h[1]) | (h[1] & h[2]) | (h[0] & h[2]);
   endfunction
   function automatic logic [31:0] tx_exp(input logic [2:0] v);
      return {!v[2] && !v[1], !v[2] && !v[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge core_clk);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do @(posedge core_clk); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic pulse(input logic [4:0] v);
      @(posedge core_clk);
      {rx_char_done, rx_parity_err, rx_frame_err, rx_overrun, rx_break_event} <= v;
      @(posedge core_clk);
      {rx_char_done, rx_parity_err, rx_frame_err, rx_overrun, rx_break_event} <= 5'h0;
   endtask
   task automatic nack_try(input logic e);
      pulse(5'b11000);
      @(negedge core_clk);
      chk(nack_send, e);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         complete_run();
      end
   end
   // ----
   // main sequence
   // ----
   initial begin
      rd = $urandom(32'h5fa0);
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         w = $urandom();
         bus(1, 5'h00, w);
         exp_m = exp_m | (w & `EVENT_MASK);
         bus(0, 5'h08, 0);
         chk(rd, exp_m);
         w = $urandom();
         bus(1, 5'h04, w);
         exp_m = exp_m & ~w;
         bus(0, 5'h08, 0);
         chk(rd, exp_m);
      end
      bus(1, 5'h08, 32'hffffffff);
      bus(0, 5'h08, 0);
      chk(rd, exp_m);
      bus(0, 5'h1c, 0);
      chk(rd, 32'h0);
      $display("mask test done");
      bus(1, 5'h04, 32'hffffffff);
      bus(1, 5'h00, 32'h18);
      for (int i = 0; i < 4; i++) begin
         {receive_dma_end, transmit_dma_end} <= i[1:0];
         bus(0, 5'h0c, 0);
         chk(rd[4:3], {i[0], i[1]});
         chk(irq, i != 0);
      end
      {receive_dma_end, transmit_dma_end} <= 2'b00;
      bus(1, 5'h04, 32'hffffffff);
      $display("dma test done");
      pulse(5'b11111);
      bus(0, 5'h0c, 0);
      bus(0, 5'h0c, 0);
      chk(rd & 32'he4, 32'he4);
      bus(1, 5'h14, 32'h100);
      bus(0, 5'h0c, 0);
      chk(rd & 32'he4, 32'h0);
      $display("sticky test done");
      w = $urandom();
      bus(1, 5'h10, w & 32'h00080000);
      @(negedge core_clk);
      chk(oversample_8, w[19]);
      chk(rx_line_filtered, rx_line);
      bus(1, 5'h10, 32'h10000000);
      repeat (8) begin
         @(negedge core_clk);
         chk(rx_line_filtered, maj(hist));
      end
      nack_try(1'b1);
      bus(1, 5'h10, 32'h00100000);
      nack_try(1'b0);
      bus(1, 5'h10, 32'h02200000);
      bus(1, 5'h14, 32'h2000);
      for (int i = 0; i < 3; i++)
         nack_try(i < 2);
      bus(0, 5'h0c, 0);
      chk(rd[10], 1'b1);
      $display("nack test done");
      bus(0, 5'h0c, 0);
      chk(rd[1], 1'b0);
      bus(1, 5'h14, 32'h40);
      for (int i = 0; i < 8; i++) begin
         {tx_holding_full, tx_shift_busy, tx_break_pending} <= i[2:0];
         bus(0, 5'h0c, 0);
         chk({rd[9], rd[1]}, tx_exp(i[2:0]));
      end
      $display("transmit test done");
      bus(1, 5'h14, 32'h10);
      w = $urandom();
      rx_char <= w[8:0];
      pulse(5'b10000);
      modem_set <= 4'h5;
      repeat (3) @(posedge core_clk);
      bus(0, 5'h0c, 0);
      chk(rd[0], 1'b1);
      chk(rd[19:16], 4'h5);
      bus(0, 5'h18, 0);
      chk(rd[8:0], w[8:0]);
      bus(0, 5'h0c, 0);
      chk(rd[0], 1'b0);
      chk(rd[19:16], 4'h0);
      $display("receive test done");
      complete_run();
   end
endmodule
